// >>> verilog/jbsdp_pkg.sv
// shared constants and types of the test access and debug port
package jbsdp_pkg;

   // ******************************************************
   // instruction register
   // ******************************************************
   localparam int        IR_W         = 4;
   localparam logic [3:0] IR_EXTEST   = 4'h0;
   localparam logic [3:0] IR_IDCODE   = 4'h1;
   localparam logic [3:0] IR_SAMPLE   = 4'h2;
   localparam logic [3:0] IR_DBG_DATA = 4'h8;
   localparam logic [3:0] IR_DBG_ACC  = 4'h9;
   localparam logic [3:0] IR_DEV_RST  = 4'hc;
   localparam logic [3:0] IR_BYPASS   = 4'hf;
   localparam logic [3:0] IR_CAPTURE  = 4'h1;

   // ******************************************************
   // identification register layout
   // ******************************************************
   localparam int         ID_W        = 32;
   localparam int         ID_VER_LSB  = 28;
   localparam int         ID_PART_LSB = 12;
   localparam int         ID_MFR_LSB  = 1;
   localparam logic       ID_MARK     = 1'b1;
   // arbitrary identity values
   localparam logic [3:0]  ID_VERSION = 4'h0;
   localparam logic [15:0] ID_PART    = 16'h1234;
   localparam logic [10:0] ID_MFR     = 11'h055;

   // ******************************************************
   // debug data channel
   // ******************************************************
   localparam int         DDC_W        = 8;
   localparam logic [7:0] DDC_RESET    = 8'h00;
   localparam int         DDC_PEND_BIT = 7;
   localparam int         DDC_DEPTH    = 16;

   // ******************************************************
   // boundary cells per pin: input, output data, output enable
   // ******************************************************
   localparam int CELL_IN   = 0;
   localparam int CELL_OUT  = 1;
   localparam int CELL_OE   = 2;
   localparam int CELLS_PIN = 3;
   localparam int SYNC_N    = 3;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
      TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
   } jbsdp_tap_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } jbsdp_cpu_s;

endpackage : jbsdp_pkg

// >>> verilog/jbsdp_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module jbsdp_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // raw and filtered levels
   input  wire logic [WIDTH-1:0] rawIn,
   output logic      [WIDTH-1:0] cleanOut
);
   import jbsdp_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] filt;
   } jbsdp_sync_s;

   jbsdp_sync_s st_reg;
   jbsdp_sync_s st_next;

   initial begin
      if (WIDTH < 1) $error("jbsdp_sync: WIDTH must be at least 1");
   end

   // ******************************************************
   // stage chain; a change counts once stages two and three agree
   // ******************************************************
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = rawIn;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.filt[i] = st_reg.s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cleanOut = st_reg.filt;

endmodule : jbsdp_sync

// >>> verilog/jbsdp_fifo.sv
// debug byte fifo with registered storage
`timescale 1ns/1ps
module jbsdp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   import jbsdp_pkg::*;

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } jbsdp_fifo_s;

   jbsdp_fifo_s st_reg;
   jbsdp_fifo_s st_next;
   logic        fullNow;
   logic        emptyNow;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("jbsdp_fifo: DEPTH must be a power of two >= 2");
      if (WIDTH < 1) $error("jbsdp_fifo: WIDTH must be at least 1");
   end

   assign emptyNow = (st_reg.wp == st_reg.rp);
   assign fullNow  = (st_reg.wp[AW] != st_reg.rp[AW]) &&
                     (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]);
   assign inReady  = !fullNow;
   assign outValid = !emptyNow;
   assign outData  = st_reg.mem[st_reg.rp[AW-1:0]];

   // ******************************************************
   // pointer and storage update
   // ******************************************************
   always_comb begin
      st_next = st_reg;
      if (inValid && !fullNow) begin
         st_next.mem[st_reg.wp[AW-1:0]] = inData;
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (outReady && !emptyNow) begin
         st_next.rp = st_reg.rp + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

endmodule : jbsdp_fifo

// >>> verilog/jbsdp_port.sv
// test access port, boundary scan and debug data channel
// Notes on behaviour
// - cpu byte write to debug channel queues it for debugger, sets pending
// - cpu read returns stored bits 6..0 with pending flag in bit 7
// - channel reachable only with debug fuse and debugger access, else io
// - port works only with enable fuse set and disable bit clear
// - programming runs over the four test pins, no high voltage; the code has no programming instruction, only the debugFuseProgReq grant
// - with either lock bit set, debug fuse programming needs chip erase
// - idcode is the instruction after test logic reset
// - entering reset puts every pin output at high impedance at once; under extest the code keeps driving the latched enables
// - reset from low reset pin or device reset instruction with one
// - extest drives output latches onto pins as soon as loaded
// - sample/preload captures pins without disturbing normal operation
// - scan works with fast test clock or stopped chip clock; the code samples tck on the chip clock, which must run and be faster
// - bypass is one stage loading zero at capture
// - data registers: bypass, identification, reset, boundary chain
// - chain drives and observes digital pins and analog boundary; the code chain has digital pin cells only
// - idcode, bypass, sample/preload, extest, device reset instructions
// - four-bit instruction register with extest 0, idcode 1, c, f
// - reset register holds reset while one, output not latched
// - every shift register moves least significant bit first
// - identification: version, part number, maker code, bit 0 one
`timescale 1ns/1ps
module jbsdp_port #(
   parameter int NPINS = 8
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // test pins
   input  wire logic                 tck,
   input  wire logic                 tms,
   input  wire logic                 tdi,
   output logic                      tdo,
   output logic                      tdoOe,
   // fuses and control bits
   input  wire logic                 testPortEnableFuse,
   input  wire logic                 testPortDisableBit,
   input  wire logic                 debugEnableFuse,
   input  wire logic                 lockBitOne,
   input  wire logic                 lockBitTwo,
   // debug fuse programming guard
   input  wire logic                 debugFuseProgReq,
   input  wire logic                 chipEraseDone,
   output logic                      debugFuseProgGrant,
   // cpu access at the shared address
   input  wire jbsdp_pkg::jbsdp_cpu_s cpuReq,
   output logic                      cpuWrReady,
   output logic [7:0]                cpuRdata,
   output jbsdp_pkg::jbsdp_cpu_s     ioReq,
   input  wire logic [7:0]           ioRdata,
   // reset
   input  wire logic                 extResetN,
   output logic                      deviceReset,
   // pins and core side
   input  wire logic [NPINS-1:0]     coreOut,
   input  wire logic [NPINS-1:0]     coreOe,
   input  wire logic [NPINS-1:0]     pinIn,
   output logic      [NPINS-1:0]     pinOut,
   output logic      [NPINS-1:0]     pinOe
);
   import jbsdp_pkg::*;

   localparam int BSR_W = CELLS_PIN * NPINS;

   initial begin
      if (NPINS < 1) $error("jbsdp_port: NPINS must be at least 1");
   end

   typedef struct packed {
      jbsdp_tap_e       tap;
      logic [IR_W-1:0]  ir;
      logic [IR_W-1:0]  irSh;
      logic             bypassSh;
      logic [ID_W-1:0]  idSh;
      logic             rstSh;
      logic [BSR_W-1:0] bsrSh;
      logic [BSR_W-1:0] bsrLat;
      logic [DDC_W-1:0] ddSh;
      logic             accSh;
      logic             accEn;
      logic             tdo;
      logic             tckPrev;
      logic [DDC_W-1:0] lastByte;
      logic [DDC_W-1:0] rdata;
      logic             erased;
   } jbsdp_port_s;

   jbsdp_port_s st_reg;
   jbsdp_port_s st_next;

   logic [2:0]       syncOut;
   logic             tckS;
   logic             tmsS;
   logic             tdiS;
   logic             tckRise;
   logic             tckFall;
   logic             portOn;
   logic             chanSel;
   logic             fifoInValid;
   logic             fifoInReady;
   logic             pending;
   logic             fifoPop;
   logic [DDC_W-1:0] fifoHead;
   logic             serialOut;
   logic             rstHold;
   logic             extestOn;
   logic [ID_W-1:0]  idValue;
   logic [BSR_W-1:0] bsrCapture;

   // ******************************************************
   // test pin sampling on the chip clock
   // ******************************************************
   jbsdp_sync #(
      .WIDTH (3)
   ) jbsdp_sync_inst (
      .clk      (clk),
      .rst      (rst),
      .rawIn    ({tdi, tms, tck}),
      .cleanOut (syncOut)
   );

   assign tckS    = syncOut[0];
   assign tmsS    = syncOut[1];
   assign tdiS    = syncOut[2];
   assign tckRise = tckS && !st_reg.tckPrev;
   assign tckFall = !tckS && st_reg.tckPrev;

   assign portOn = testPortEnableFuse && !testPortDisableBit;

   // ******************************************************
   // debug data channel and shared address
   // ******************************************************
   assign chanSel     = debugEnableFuse && st_reg.accEn;
   assign fifoInValid = chanSel && cpuReq.wr;
   assign cpuWrReady  = chanSel ? fifoInReady : 1'b1;
   assign ioReq       = chanSel ? '0 : cpuReq;
   assign cpuRdata    = st_reg.rdata;
   assign fifoPop     = portOn && tckRise && st_reg.tap == TAP_UPD_DR &&
                        st_reg.ir == IR_DBG_DATA;

   jbsdp_fifo #(
      .WIDTH (DDC_W),
      .DEPTH (DDC_DEPTH)
   ) jbsdp_fifo_inst (
      .clk      (clk),
      .rst      (rst),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (cpuReq.wdata),
      .outValid (pending),
      .outReady (fifoPop),
      .outData  (fifoHead)
   );

   // ******************************************************
   // debug fuse programming guard
   // ******************************************************
   assign debugFuseProgGrant = debugFuseProgReq &&
      (!(lockBitOne || lockBitTwo) || st_reg.erased);

   // ******************************************************
   // reset, pin drive and capture values
   // ******************************************************
   assign rstHold     = portOn && st_reg.ir == IR_DEV_RST &&
                        st_reg.rstSh;
   assign deviceReset = !extResetN || rstHold;
   assign extestOn    = portOn && st_reg.ir == IR_EXTEST;
   assign idValue     = {ID_VERSION, ID_PART, ID_MFR, ID_MARK};

   for (genvar p = 0; p < NPINS; p++) begin : g_pin
      assign bsrCapture[CELLS_PIN*p+CELL_IN]  = pinIn[p];
      assign bsrCapture[CELLS_PIN*p+CELL_OUT] = coreOut[p];
      assign bsrCapture[CELLS_PIN*p+CELL_OE]  = coreOe[p];
      // extest drives latches; otherwise core, cut off during reset
      assign pinOut[p] = extestOn ? st_reg.bsrLat[CELLS_PIN*p+CELL_OUT]
                                  : coreOut[p];
      assign pinOe[p]  = extestOn ? st_reg.bsrLat[CELLS_PIN*p+CELL_OE]
                                  : (coreOe[p] && !deviceReset);
   end

   // ******************************************************
   // serial output selection
   // ******************************************************
   always_comb begin
      serialOut = st_reg.bypassSh;
      if (st_reg.tap == TAP_SH_IR) begin
         serialOut = st_reg.irSh[0];
      end else begin
         case (st_reg.ir)
            IR_EXTEST, IR_SAMPLE: serialOut = st_reg.bsrSh[0];
            IR_IDCODE:            serialOut = st_reg.idSh[0];
            IR_DEV_RST:           serialOut = st_reg.rstSh;
            IR_DBG_DATA:          serialOut = st_reg.ddSh[0];
            IR_DBG_ACC:           serialOut = st_reg.accSh;
            default:              serialOut = st_reg.bypassSh;
         endcase
      end
   end

   assign tdo   = st_reg.tdo;
   assign tdoOe = portOn && (st_reg.tap == TAP_SH_DR ||
                             st_reg.tap == TAP_SH_IR);

   // ******************************************************
   // tap controller and data registers
   // ******************************************************
   function automatic jbsdp_tap_e tapStep(jbsdp_tap_e s, logic m);
      case (s)
         TAP_RESET:  tapStep = m ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   tapStep = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tapStep = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tapStep = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  tapStep = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tapStep = m ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: tapStep = m ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: tapStep = m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tapStep = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tapStep = m ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: tapStep = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  tapStep = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tapStep = m ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: tapStep = m ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: tapStep = m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tapStep = m ? TAP_SEL_DR : TAP_IDLE;
         default:    tapStep = TAP_RESET;
      endcase
   endfunction : tapStep

   always_comb begin
      st_next         = st_reg;
      st_next.tckPrev = tckS;
      // cpu side of the shared address, read data registered
      if (fifoInValid && fifoInReady) begin
         st_next.lastByte = cpuReq.wdata;
      end
      if (cpuReq.rd) begin
         st_next.rdata = chanSel ?
            {pending, st_reg.lastByte[DDC_PEND_BIT-1:0]} : ioRdata;
      end
      if (chipEraseDone) begin
         st_next.erased = 1'b1;
      end
      if (!portOn) begin
         st_next.tap = TAP_RESET;
         st_next.ir  = IR_IDCODE;
         st_next.tdo = 1'b0;
      end else if (tckFall) begin
         st_next.tdo = serialOut;
      end else if (tckRise) begin
         st_next.tap = tapStep(st_reg.tap, tmsS);
         case (st_reg.tap)
            TAP_RESET: begin
               st_next.ir = IR_IDCODE;
            end
            TAP_CAP_IR: begin
               st_next.irSh = IR_CAPTURE;
            end
            TAP_SH_IR: begin
               st_next.irSh = {tdiS, st_reg.irSh[IR_W-1:1]};
            end
            TAP_UPD_IR: begin
               st_next.ir = st_reg.irSh;
            end
            TAP_CAP_DR: begin
               case (st_reg.ir)
                  IR_EXTEST, IR_SAMPLE: st_next.bsrSh = bsrCapture;
                  IR_IDCODE:   st_next.idSh  = idValue;
                  IR_DBG_DATA: st_next.ddSh  = fifoHead;
                  IR_DBG_ACC:  st_next.accSh = st_reg.accEn;
                  IR_DEV_RST:  st_next.rstSh = st_reg.rstSh;
                  default:     st_next.bypassSh = 1'b0;
               endcase
            end
            TAP_SH_DR: begin
               case (st_reg.ir)
                  IR_EXTEST, IR_SAMPLE:
                     st_next.bsrSh = {tdiS, st_reg.bsrSh[BSR_W-1:1]};
                  IR_IDCODE:
                     st_next.idSh = {tdiS, st_reg.idSh[ID_W-1:1]};
                  IR_DBG_DATA:
                     st_next.ddSh = {tdiS, st_reg.ddSh[DDC_W-1:1]};
                  IR_DBG_ACC:  st_next.accSh = tdiS;
                  IR_DEV_RST:  st_next.rstSh = tdiS;
                  default:     st_next.bypassSh = tdiS;
               endcase
            end
            TAP_UPD_DR: begin
               case (st_reg.ir)
                  IR_EXTEST, IR_SAMPLE:
                     st_next.bsrLat = st_reg.bsrSh;
                  IR_DBG_ACC: st_next.accEn = st_reg.accSh;
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg          <= '0;
         st_reg.tap      <= TAP_RESET;
         st_reg.ir       <= IR_IDCODE;
         st_reg.lastByte <= DDC_RESET;
         st_reg.rdata    <= DDC_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

endmodule : jbsdp_port

// >>> test/jbsdp_port_sva.sv
// assertions on the ports of the test access and debug port
`timescale 1ns/1ps
module jbsdp_port_sva #(
   parameter int NPINS = 8
) (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // test port
   input wire logic                  tck,
   input wire logic                  tdo,
   input wire logic                  tdoOe,
   // fuses and guard
   input wire logic                  testPortEnableFuse,
   input wire logic                  testPortDisableBit,
   input wire logic                  debugEnableFuse,
   input wire logic                  lockBitOne,
   input wire logic                  lockBitTwo,
   input wire logic                  debugFuseProgReq,
   input wire logic                  chipEraseDone,
   input wire logic                  debugFuseProgGrant,
   // cpu side
   input wire jbsdp_pkg::jbsdp_cpu_s cpuReq,
   input wire jbsdp_pkg::jbsdp_cpu_s ioReq,
   input wire logic [7:0]            ioRdata,
   input wire logic [7:0]            cpuRdata,
   // reset and pins
   input wire logic                  extResetN,
   input wire logic                  deviceReset,
   input wire logic [NPINS-1:0]      pinOe
);
   import jbsdp_pkg::*;
   logic eraseSeen_reg;
   always_ff @(posedge clk) begin
      if (rst) eraseSeen_reg <= 1'b0;
      else if (chipEraseDone) eraseSeen_reg <= 1'b1;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ********************
   // assertions
   // ********************
   AST_PORT_GATE: assert property (
      tdoOe |-> testPortEnableFuse && !testPortDisableBit)
      else $error("tdo driven with port off");
   AST_EXT_RESET: assert property (
      !extResetN |-> deviceReset) else $error("reset pin ignored");
   AST_RESET_HIGHZ: assert property (
      deviceReset |-> pinOe == '0) else $error("pin driven in reset");
   AST_GRANT_LOCK: assert property (
      (lockBitOne || lockBitTwo) && !eraseSeen_reg && !chipEraseDone
      |-> !debugFuseProgGrant) else $error("grant while locked");
   AST_GRANT_FREE: assert property (
      debugFuseProgReq && !lockBitOne && !lockBitTwo
      |-> debugFuseProgGrant) else $error("grant missing");
   AST_IO_PASS: assert property (
      cpuReq.wr && !debugEnableFuse
      |-> ioReq.wr && ioReq.wdata == cpuReq.wdata)
      else $error("io write lost");
   AST_IO_READ: assert property (
      cpuReq.rd && !debugEnableFuse |=> cpuRdata == $past(ioRdata))
      else $error("io read data wrong");
   AST_PEND: assert property (
      (cpuReq.wr && debugEnableFuse && !ioReq.wr) ##2 cpuReq.rd
      |=> cpuRdata == {1'b1, $past(cpuReq.wdata[6:0], 3)})
      else $error("pending read wrong");
   AST_TDO_FALL: assert property (
      $changed(tdo) |-> !$past(tck, 2) && !$past(tck, 3))
      else $error("tdo moved without tck fall");
   COV_SCAN_RESET: cover property (deviceReset && extResetN);
   COV_GRANT: cover property (debugFuseProgGrant && lockBitTwo);
   COV_SHIFT: cover property (tdoOe ##1 tdoOe);
endmodule : jbsdp_port_sva

bind jbsdp_port jbsdp_port_sva #(.NPINS(NPINS)) jbsdp_port_sva_inst (.*);

// >>> test/jbsdp_tap_ctl.sv
// controller model on the four test pins, driving tck, tms and tdi and reading tdo
`timescale 1ns/1ps
module jbsdp_tap_ctl (
   // test pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   logic tdoSeen;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one test clock period, tdo taken late in the high phase
   task automatic step(input logic m, input logic d);
      tms = m;
      tdi = d;
      #80 tck = 1'b1;
      #80 tdoSeen = tdo;
      tck = 1'b0;
   endtask : step
   // five ones reach test logic reset, then idle
   task automatic idle();
      repeat (5) step(1'b1, tdi);
      step(1'b0, tdi);
   endtask : idle
   // idle to idle scan of n bits, tdi left at the last data bit after
   task automatic scan(input logic ir, input int n,
                       input logic [31:0] din, output logic [31:0] dout);
      dout = '0;
      step(1'b1, tdi);
      if (ir) step(1'b1, tdi);
      step(1'b0, tdi);
      step(1'b0, tdi);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i]);
         dout[i] = tdoSeen;
      end
      step(1'b1, ~tdi);
      step(1'b0, ~tdi);
      #160;
   endtask : scan
endmodule : jbsdp_tap_ctl

// >>> test/tb_jbsdp_port.sv
// self-checking bench of the test access and debug port
`timescale 1ns/1ps
module tb_jbsdp_port;
   import jbsdp_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        tck, tms, tdi, tdo, tdoOe;
   logic        testPortEnableFuse = 1'b1;
   logic        testPortDisableBit = 1'b0;
   logic        debugEnableFuse = 1'b0;
   logic        lockBitOne = 1'b0;
   logic        lockBitTwo = 1'b0;
   logic        debugFuseProgReq = 1'b0;
   logic        chipEraseDone = 1'b0;
   logic        extResetN = 1'b1;
   logic        debugFuseProgGrant, cpuWrReady, deviceReset;
   jbsdp_cpu_s  cpuReq = '0;
   jbsdp_cpu_s  ioReq;
   logic [7:0]  cpuRdata;
   logic [7:0]  ioRdata = 8'h77;
   logic [7:0]  coreOut = 8'h3c;
   logic [7:0]  coreOe = 8'hf0;
   logic [7:0]  pinIn = 8'hc3;
   logic [7:0]  pinOut, pinOe;
   logic [31:0] v;
   int          errorCnt = 0;
   int          nTests = 0;
   always #10 clk = ~clk;
   jbsdp_port #(.NPINS(8)) jbsdp_port_inst (.*);
   jbsdp_tap_ctl jbsdp_tap_ctl_inst (.tck(tck), .tms(tms), .tdi(tdi),
                                     .tdo(tdoOe ? tdo : ~tdo));
   // ********************
   // helpers
   // ********************
   task automatic checkVal(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         errorCnt++;
      end
   endtask : checkVal
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic irLoad(input logic [3:0] code);
      jbsdp_tap_ctl_inst.scan(1'b1, 4, {28'h0, code}, v);
   endtask : irLoad
   task automatic drScan(input int n, input logic [31:0] din);
      jbsdp_tap_ctl_inst.scan(1'b0, n, din, v);
   endtask : drScan
   task automatic cpuWr(input logic [7:0] d);
      tick();
      cpuReq = '{wr: 1'b1, rd: 1'b0, wdata: d};
      tick();
      cpuReq = '0;
   endtask : cpuWr
   task automatic cpuRd(input string what, input logic [7:0] exp,
                        input logic [7:0] mask);
      tick();
      cpuReq.rd = 1'b1;
      tick();
      cpuReq.rd = 1'b0;
      tick();
      checkVal(what, exp & mask, cpuRdata & mask);
   endtask : cpuRd
   task automatic endSim();
      $display("checks %0d mismatches %0d", nTests, errorCnt);
      if (errorCnt == 0 && nTests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : endSim
   // ********************
   // scenarios
   // ********************
   task automatic testIdcode();
      jbsdp_tap_ctl_inst.idle();
      drScan(32, 32'h0);
      checkVal("idcode", {ID_VERSION, ID_PART, ID_MFR, ID_MARK},
               v);
      $display("idcode test done");
   endtask : testIdcode
   task automatic testBypass();
      irLoad(IR_BYPASS);
      checkVal("ir capture", IR_CAPTURE, v);
      drScan(2, 32'h1);
      checkVal("bypass", 32'h2, v);
      $display("bypass test done");
   endtask : testBypass
   task automatic testReset();
      irLoad(IR_DEV_RST);
      drScan(1, 32'h1);
      checkVal("scan reset", 1, deviceReset);
      checkVal("scan reset oe", 0, pinOe);
      drScan(1, 32'h0);
      checkVal("scan reset off", 0, deviceReset);
      tick();
      extResetN = 1'b0;
      tick();
      checkVal("pin reset", 1, deviceReset);
      checkVal("pin reset oe", 0, pinOe);
      extResetN = 1'b1;
      $display("reset test done");
   endtask : testReset
   task automatic testBoundary();
      logic [31:0] din = '0;
      logic [31:0] exp = '0;
      logic [7:0]  lat = 8'h5a;
      for (int p = 0; p < 8; p++) begin
         din[3*p+1] = lat[p];
         din[3*p+2] = 1'b1;
         exp[3*p] = pinIn[p];
         exp[3*p+1] = coreOut[p];
         exp[3*p+2] = coreOe[p];
      end
      irLoad(IR_SAMPLE);
      drScan(24, din);
      checkVal("sample capture", exp, v);
      checkVal("sample pins", coreOut, pinOut);
      irLoad(IR_EXTEST);
      checkVal("extest data", lat, pinOut);
      checkVal("extest oe", 8'hff, pinOe);
      irLoad(IR_BYPASS);
      checkVal("core oe", coreOe, pinOe);
      $display("boundary test done");
   endtask : testBoundary
   task automatic testLock();
      tick();
      debugFuseProgReq = 1'b1;
      tick();
      checkVal("grant open", 1, debugFuseProgGrant);
      lockBitOne = 1'b1;
      tick();
      checkVal("grant lock one", 0, debugFuseProgGrant);
      lockBitOne = 1'b0;
      lockBitTwo = 1'b1;
      tick();
      checkVal("grant lock two", 0, debugFuseProgGrant);
      chipEraseDone = 1'b1;
      tick();
      chipEraseDone = 1'b0;
      tick();
      checkVal("grant erased", 1, debugFuseProgGrant);
      $display("lock test done");
   endtask : testLock
   task automatic testChannel();
      cpuWr(8'h11);
      cpuRd("io read", 8'h77, 8'hff);
      tick();
      debugEnableFuse = 1'b1;
      cpuRd("no access", 8'h77, 8'hff);
      irLoad(IR_DBG_ACC);
      drScan(1, 32'h1);
      cpuRd("empty", 8'h00, 8'h80);
      cpuWr(8'ha5);
      cpuRd("pending", 8'ha5, 8'hff);
      for (int i = 1; i < DDC_DEPTH; i++) cpuWr(8'(32'h20 + i));
      tick();
      checkVal("full", 0, cpuWrReady);
      irLoad(IR_DBG_DATA);
      for (int i = 0; i < DDC_DEPTH; i++) begin
         drScan(8, 32'h0);
         checkVal("fetch", (i == 0) ? 32'ha5 : 32'h20 + i, v);
      end
      cpuRd("cleared", 8'h00, 8'h80);
      $display("channel test done");
   endtask : testChannel
   task automatic testDisable();
      for (int k = 0; k < 2; k++) begin
         tick();
         testPortEnableFuse = (k == 1);
         testPortDisableBit = (k == 1);
         irLoad(IR_DEV_RST);
         checkVal("off ir", 32'hf, v);
         drScan(1, 32'h1);
         checkVal("off reset", 0, deviceReset);
         checkVal("off tdo oe", 0, tdoOe);
      end
      tick();
      testPortDisableBit = 1'b0;
      $display("disable test done");
      testIdcode();
   endtask : testDisable
   initial begin
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) tick();
      testIdcode();
      testBypass();
      testReset();
      testBoundary();
      testLock();
      testChannel();
      testDisable();
      endSim();
   end
   initial begin
      repeat (100000) @(posedge clk);
      errorCnt++;
      endSim();
   end
endmodule : tb_jbsdp_port
